/* File: hw/uam_device.sv */
// Device-end UART: double-buffered transmit, address filter, break detect
`timescale 1ns/1ps
`default_nettype none
`include "uam_regs.svh"
// Function
// (RULE_01) Filter on, select clear: flag at ninth bit
// (RULE_02) Select set: flag at stop; zero ninth silent
// (RULE_03) Eleven low bit times set break flag
// (RULE_04) Break flag holds until cleared or reset
// (RULE_05) Enabled break reset forces programming-mode reset
// (RULE_06) Buffered character follows after one stop bit
// (RULE_07) Buffer disabled behaves single-buffered
// (RULE_08) Software enables buffering only modes one-three
// (RULE_09) Write to empty buffer loads, interrupts at once
// (RULE_10) Last-character interrupt optional, position selectable
// (RULE_11) Further write interrupts at stop start or end
// (RULE_12) Software avoids writing at final stop bit
// (RULE_13) Unbuffered ninth bit fixed until transmit done
// (RULE_14) Buffered ninth bit travels with data byte
// (RULE_15) Modes two, three carry nine data bits
// (RULE_16) Filter passes only ninth-bit-one frames
// (RULE_17) Filter ignored mode zero, kept clear mode one
// (RULE_18) Filtered frame needs given or broadcast address
// (RULE_19) Given match compares masked bits only
// (RULE_20) Broadcast match uses address OR mask
// (RULE_21) Reset clears address and mask registers
// (RULE_22) Load only when flag clear and filter passes
// (RULE_23) Missing stop bit sets sticky framing flag
// (RULE_24) Address checked on low byte at final shift
module uam_device #(
  parameter int BIT_CYCLES = `UAM_BIT_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  uam_link_if.dev         link,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  output logic            ispResetReq
);
  localparam logic [15:0] BIT_LAST  = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);
  localparam logic [19:0] BRK_LAST  = 20'(`UAM_BREAK_BITS * BIT_CYCLES - 1);

  logic [1:0] mode, next_mode;
  logic       addrFilterEn, next_addrFilterEn, rxEn, next_rxEn;
  logic       txNinth, next_txNinth, rxNinth, next_rxNinth;
  logic       txFlag, next_txFlag, rxFlag, next_rxFlag;
  logic       dbufEn, next_dbufEn, irqPos, next_irqPos, lastSel, next_lastSel;
  logic       feFlag, next_feFlag, breakFlag, next_breakFlag;
  logic       brkRstEn, next_brkRstEn, feSel, next_feSel, next_isp;
  logic [7:0] rxBuf, next_rxBuf, slave_addr_reg, next_slave_addr_reg, slave_addr_mask, next_slave_addr_mask;
  logic [7:0] next_rdData;
  uam_pkg::uam_tx_state_t txState, next_txState;
  uam_pkg::uam_rx_state_t rxState, next_rxState;
  logic [15:0] txCnt, next_txCnt, rxCnt, next_rxCnt;
  logic [3:0]  txBit, next_txBit, rxBit, next_rxBit, lastBit;
  logic [8:0]  txShift, next_txShift, bufData, next_bufData;
  logic [8:0]  rxShift, next_rxShift, shiftIn, candShift;
  logic        bufFull, next_bufFull, txIrqDone, next_txIrqDone;
  logic        txLine, next_txLine, rxEarly, next_rxEarly;
  logic [19:0] brkCnt, next_brkCnt;
  logic        wrCtrl, wrBuf, wrExt, rxd, txBitEnd, rxBitEnd, irqPoint, txSet;
  logic        filt9, earlyPoint, stopPoint, finalShift, accept, brkHit;
  logic [7:0]  candByte;
  logic        candNinth;

  function automatic logic addrHit(input logic [7:0] b, input logic [7:0] sa,
                                   input logic [7:0] sm);
    logic [7:0] bc;
    bc = sa | sm;
    // (RULE_19) masked given match
    // (RULE_20) broadcast zeros are don't-care
    addrHit = (((b ^ sa) & sm) == 8'h00) || ((b & bc) == bc);
  endfunction

  assign link.devTx = txLine;
  assign rxd        = link.nodeTx;

  always_comb begin
    wrCtrl  = regWr && (regAddr == `UAM_ADDR_CTRL);
    wrBuf   = regWr && (regAddr == `UAM_ADDR_BUF);
    wrExt   = regWr && (regAddr == `UAM_ADDR_EXT);
    // (RULE_15) nine data bits in modes two and three
    lastBit = mode[1] ? 4'h8 : 4'h7;
    // (RULE_17) filter has no effect in mode zero
    filt9   = addrFilterEn && mode[1];
    next_txState   = txState;
    next_txBit     = txBit;
    next_txShift   = txShift;
    next_bufData   = bufData;
    next_bufFull   = bufFull;
    next_txIrqDone = txIrqDone;
    txSet          = 1'b0;
    txBitEnd = (txCnt == BIT_LAST);
    next_txCnt = (txState == uam_pkg::UAM_TX_IDLE || txBitEnd) ? 16'h0000
                                                                : txCnt + 16'h0001;
    irqPoint = (txState == uam_pkg::UAM_TX_STOP) &&
               (irqPos ? txBitEnd : (txCnt == 16'h0000));
    case (txState)
      uam_pkg::UAM_TX_IDLE: begin
        if (wrBuf) begin
          next_txShift   = {txNinth, regWrData};
          next_txState   = uam_pkg::UAM_TX_START;
          next_txIrqDone = 1'b0;
          // (RULE_09) empty buffer frees at once
          txSet          = dbufEn;
        end
      end
      uam_pkg::UAM_TX_START: begin
        if (txBitEnd) begin
          next_txState = uam_pkg::UAM_TX_DATA;
          next_txBit   = 4'h0;
        end
      end
      uam_pkg::UAM_TX_DATA: begin
        if (txBitEnd) begin
          next_txShift = {1'b0, txShift[8:1]};
          next_txBit   = txBit + 4'h1;
          if (txBit == lastBit) begin
            next_txState = uam_pkg::UAM_TX_STOP;
          end
        end
      end
      uam_pkg::UAM_TX_STOP: begin
        // (RULE_10) last interrupt only when selected
        // (RULE_11) pending character interrupts at position
        if (irqPoint && (!dbufEn || bufFull || lastSel)) begin
          txSet          = 1'b1;
          next_txIrqDone = 1'b1;
        end
        if (txBitEnd) begin
          // (RULE_06) next frame after a single stop bit
          if (bufFull) begin
            next_txShift   = bufData;
            next_bufFull   = 1'b0;
            next_txState   = uam_pkg::UAM_TX_START;
            next_txIrqDone = 1'b0;
            // Late write missed the start-of-stop point
            if (!txIrqDone) begin
              txSet = 1'b1;
            end
          end else begin
            next_txState = uam_pkg::UAM_TX_IDLE;
          end
        end
      end
      default: next_txState = uam_pkg::UAM_TX_IDLE;
    endcase
    // (RULE_14) ninth bit buffered with the byte
    // (RULE_07) busy single-buffer writes are dropped
    if (wrBuf && txState != uam_pkg::UAM_TX_IDLE && dbufEn) begin
      next_bufData = {txNinth, regWrData};
      next_bufFull = 1'b1;
    end
    case (next_txState)
      uam_pkg::UAM_TX_START: next_txLine = 1'b0;
      // (RULE_13) unbuffered ninth bit read live as it leaves
      uam_pkg::UAM_TX_DATA:  next_txLine = (next_txBit == 4'h8 && !dbufEn) ? txNinth
                                                                           : next_txShift[0];
      default:               next_txLine = 1'b1;
    endcase

    next_rxState = rxState;
    next_rxBit   = rxBit;
    next_rxShift = rxShift;
    next_rxEarly = rxEarly;
    next_rxCnt   = rxCnt + 16'h0001;
    rxBitEnd     = (rxCnt == BIT_LAST);
    shiftIn      = {rxd, rxShift[8:1]};
    case (rxState)
      uam_pkg::UAM_RX_IDLE: begin
        next_rxCnt   = 16'h0000;
        next_rxEarly = 1'b0;
        if (rxEn && !rxd) begin
          next_rxState = uam_pkg::UAM_RX_START;
        end
      end
      uam_pkg::UAM_RX_START: begin
        if (rxCnt == HALF_LAST) begin
          next_rxCnt   = 16'h0000;
          next_rxBit   = 4'h0;
          next_rxState = rxd ? uam_pkg::UAM_RX_IDLE : uam_pkg::UAM_RX_DATA;
        end
      end
      uam_pkg::UAM_RX_DATA: begin
        if (rxBitEnd) begin
          next_rxCnt   = 16'h0000;
          next_rxShift = shiftIn;
          next_rxBit   = rxBit + 4'h1;
          if (rxBit == lastBit) begin
            next_rxState = uam_pkg::UAM_RX_STOP;
          end
        end
      end
      uam_pkg::UAM_RX_STOP: begin
        if (rxBitEnd) begin
          next_rxState = uam_pkg::UAM_RX_IDLE;
        end
      end
      default: next_rxState = uam_pkg::UAM_RX_IDLE;
    endcase
    // (RULE_01) early decision during the ninth bit
    earlyPoint = (rxState == uam_pkg::UAM_RX_DATA) && rxBitEnd && (rxBit == 4'h8) &&
                 filt9 && !feSel;
    if (earlyPoint) begin
      next_rxEarly = 1'b1;
    end
    // (RULE_02) otherwise decide at the stop bit
    stopPoint  = (rxState == uam_pkg::UAM_RX_STOP) && rxBitEnd;
    finalShift = earlyPoint || (stopPoint && !rxEarly);
    candShift  = earlyPoint ? shiftIn : rxShift;
    // (RULE_24) low eight bits at final shift
    candByte   = mode[1] ? candShift[7:0] : candShift[8:1];
    candNinth  = mode[1] ? candShift[8] : rxd;
    // (RULE_22) load only into a free buffer
    // (RULE_16) ninth bit must be one
    // (RULE_18) and address must match
    accept = !rxFlag && (filt9 ? (candNinth && addrHit(candByte, slave_addr_reg, slave_addr_mask)) :
                         (addrFilterEn && mode == 2'h1) ? rxd : 1'b1);
    next_rxBuf   = (finalShift && accept) ? candByte : rxBuf;
    next_rxNinth = (finalShift && accept) ? candNinth : rxNinth;

    // (RULE_03) consecutive low time counter
    next_brkCnt = rxd ? 20'h00000 : (brkCnt <= BRK_LAST) ? brkCnt + 20'h00001 : brkCnt;
    brkHit      = !rxd && (brkCnt == BRK_LAST);
    // (RULE_05) break reset request when enabled
    next_isp    = brkHit && rxEn && brkRstEn;

    // Hardware set wins over a same-cycle software clear
    next_rxFlag  = (finalShift && accept) || (wrCtrl ? regWrData[`UAM_CTRL_RXF] : rxFlag);
    next_txFlag  = txSet || (wrCtrl ? regWrData[`UAM_CTRL_TXF] : txFlag);
    // (RULE_23) missing stop bit, except filtered zero-ninth frame with select set
    next_feFlag  = (stopPoint && !rxd && !(filt9 && feSel && !rxShift[8])) ||
                   (wrExt ? regWrData[`UAM_EXT_FE] : feFlag);
    // (RULE_04) sticky until software clears
    next_breakFlag = brkHit || (wrExt ? regWrData[`UAM_EXT_BRK] : breakFlag);
    next_mode         = wrCtrl ? regWrData[`UAM_CTRL_MODE] : mode;
    next_addrFilterEn = wrCtrl ? regWrData[`UAM_CTRL_FILT] : addrFilterEn;
    next_rxEn         = wrCtrl ? regWrData[`UAM_CTRL_RXEN] : rxEn;
    next_txNinth      = wrCtrl ? regWrData[`UAM_CTRL_TB8] : txNinth;
    next_dbufEn       = wrExt ? regWrData[`UAM_EXT_DBUF] : dbufEn;
    next_irqPos       = wrExt ? regWrData[`UAM_EXT_IRQPOS] : irqPos;
    next_lastSel      = wrExt ? regWrData[`UAM_EXT_LASTSEL] : lastSel;
    next_brkRstEn = (regWr && regAddr == `UAM_ADDR_AUX) ? regWrData[`UAM_AUX_BRKRST] : brkRstEn;
    next_feSel    = (regWr && regAddr == `UAM_ADDR_PWR) ? regWrData[`UAM_PWR_FESEL] : feSel;
    next_slave_addr_reg    = (regWr && regAddr == `UAM_ADDR_SLAVE_ADDR_REG) ? regWrData : slave_addr_reg;
    next_slave_addr_mask    = (regWr && regAddr == `UAM_ADDR_SLAVE_ADDR_MASK) ? regWrData : slave_addr_mask;
    next_rdData   = 8'h00;
    if (regRd) begin
      case (regAddr)
        `UAM_ADDR_CTRL:  next_rdData = {mode, addrFilterEn, rxEn, txNinth, rxNinth,
                                        txFlag, rxFlag};
        `UAM_ADDR_BUF:   next_rdData = rxBuf;
        `UAM_ADDR_EXT:   next_rdData = {dbufEn, irqPos, 1'b0, lastSel, feFlag, breakFlag,
                                        2'h0};
        `UAM_ADDR_AUX:   next_rdData = {1'b0, brkRstEn, 6'h00};
        `UAM_ADDR_SLAVE_ADDR_REG: next_rdData = slave_addr_reg;
        `UAM_ADDR_SLAVE_ADDR_MASK: next_rdData = slave_addr_mask;
        `UAM_ADDR_PWR:   next_rdData = {1'b0, feSel, 6'h00};
        default:         next_rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode <= 2'h0;  addrFilterEn <= 1'b0;  rxEn <= 1'b0;  txNinth <= 1'b0;
      rxNinth <= 1'b0;  txFlag <= 1'b0;  rxFlag <= 1'b0;  dbufEn <= 1'b0;
      irqPos <= 1'b0;  lastSel <= 1'b0;  feFlag <= 1'b0;  breakFlag <= 1'b0;
      brkRstEn <= 1'b0;  feSel <= 1'b0;  rxBuf <= 8'h00;
      // (RULE_21) all-don't-care address after reset
      slave_addr_reg <= 8'h00;
      slave_addr_mask <= 8'h00;
      regRdData <= 8'h00;  ispResetReq <= 1'b0;
      txState <= uam_pkg::UAM_TX_IDLE;  txCnt <= 16'h0000;  txBit <= 4'h0;
      txShift <= 9'h000;  bufData <= 9'h000;  bufFull <= 1'b0;
      txIrqDone <= 1'b0;  txLine <= 1'b1;
      rxState <= uam_pkg::UAM_RX_IDLE;  rxCnt <= 16'h0000;  rxBit <= 4'h0;
      rxShift <= 9'h000;  rxEarly <= 1'b0;  brkCnt <= 20'h00000;
    end else begin
      mode <= next_mode;  addrFilterEn <= next_addrFilterEn;  rxEn <= next_rxEn;
      txNinth <= next_txNinth;  rxNinth <= next_rxNinth;  txFlag <= next_txFlag;
      rxFlag <= next_rxFlag;  dbufEn <= next_dbufEn;  irqPos <= next_irqPos;
      lastSel <= next_lastSel;  feFlag <= next_feFlag;  breakFlag <= next_breakFlag;
      brkRstEn <= next_brkRstEn;  feSel <= next_feSel;  rxBuf <= next_rxBuf;
      slave_addr_reg <= next_slave_addr_reg;  slave_addr_mask <= next_slave_addr_mask;
      regRdData <= next_rdData;  ispResetReq <= next_isp;
      txState <= next_txState;  txCnt <= next_txCnt;  txBit <= next_txBit;
      txShift <= next_txShift;  bufData <= next_bufData;  bufFull <= next_bufFull;
      txIrqDone <= next_txIrqDone;  txLine <= next_txLine;
      rxState <= next_rxState;  rxCnt <= next_rxCnt;  rxBit <= next_rxBit;
      rxShift <= next_rxShift;  rxEarly <= next_rxEarly;  brkCnt <= next_brkCnt;
    end
  end
endmodule
`default_nettype wire

/* File: hw/uam_regs.svh */
// Register offsets, field positions and timing counts of the UART pair
`ifndef UAM_REGS_SVH
`define UAM_REGS_SVH
`define UAM_ADDR_CTRL    3'h0
`define UAM_ADDR_BUF     3'h1
`define UAM_ADDR_EXT     3'h2
`define UAM_ADDR_AUX     3'h3
`define UAM_ADDR_SLAVE_ADDR_REG   3'h4
`define UAM_ADDR_SLAVE_ADDR_MASK   3'h5
`define UAM_ADDR_PWR     3'h6
`define UAM_CTRL_MODE    7:6
`define UAM_CTRL_FILT    5
`define UAM_CTRL_RXEN    4
`define UAM_CTRL_TB8     3
`define UAM_CTRL_RB8     2
`define UAM_CTRL_TXF     1
`define UAM_CTRL_RXF     0
`define UAM_EXT_DBUF     7
`define UAM_EXT_IRQPOS   6
`define UAM_EXT_LASTSEL  4
`define UAM_EXT_FE       3
`define UAM_EXT_BRK      2
`define UAM_AUX_BRKRST   6
`define UAM_PWR_FESEL    6
`define UAM_BIT_CYCLES   87
`define UAM_BREAK_BITS   11
`define UAM_NODE_BRK_LAST 4'hB
`endif

/* File: hw/uam_pkg.sv */
// Types shared by both ends of the UART link
package uam_pkg;
  typedef enum logic [1:0] {
    UAM_TX_IDLE  = 2'b00,
    UAM_TX_START = 2'b01,
    UAM_TX_DATA  = 2'b10,
    UAM_TX_STOP  = 2'b11
  } uam_tx_state_t;
  typedef enum logic [1:0] {
    UAM_RX_IDLE  = 2'b00,
    UAM_RX_START = 2'b01,
    UAM_RX_DATA  = 2'b10,
    UAM_RX_STOP  = 2'b11
  } uam_rx_state_t;
endpackage

/* File: hw/uam_link_if.sv */
// Serial line between the device UART and a remote node
`timescale 1ns/1ps
`default_nettype none
interface uam_link_if;
  logic devTx;
  logic nodeTx;
  modport dev  (output devTx, input nodeTx);
  modport node (input devTx, output nodeTx);
endinterface
`default_nettype wire

/* File: hw/uam_node.sv */
// Remote-node UART: sends 8/9-bit frames and breaks, receives frames
`timescale 1ns/1ps
`default_nettype none
`include "uam_regs.svh"
module uam_node #(
  parameter int BIT_CYCLES = `UAM_BIT_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  uam_link_if.node        link,
  input  wire logic       nineBits,
  input  wire logic       sendReq,
  input  wire logic [8:0] sendData,
  input  wire logic       sendBreak,
  output logic            sendBusy,
  output logic            rcvValid,
  output logic      [8:0] rcvData,
  output logic            rcvFrameErr
);
  localparam logic [15:0] BIT_LAST  = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);

  uam_pkg::uam_tx_state_t txState, next_txState;
  uam_pkg::uam_rx_state_t rxState, next_rxState;
  logic [15:0] txCnt, next_txCnt, rxCnt, next_rxCnt;
  logic [3:0]  txBit, next_txBit, txLen, next_txLen, rxBit, next_rxBit, rxLast;
  logic [8:0]  txShift, next_txShift, rxShift, next_rxShift, next_rcvData;
  logic        txLine, next_txLine, next_busy, next_valid, next_ferr, rxd, txBitEnd;

  assign link.nodeTx = txLine;
  assign rxd         = link.devTx;

  always_comb begin
    next_txState = txState;
    next_txBit   = txBit;
    next_txLen   = txLen;
    next_txShift = txShift;
    txBitEnd     = (txCnt == BIT_LAST);
    next_txCnt   = (txState == uam_pkg::UAM_TX_IDLE || txBitEnd) ? 16'h0000
                                                                  : txCnt + 16'h0001;
    case (txState)
      uam_pkg::UAM_TX_IDLE: begin
        // Break is a long all-zero frame: start plus twelve low bits
        if (sendBreak) begin
          next_txShift = 9'h000;
          next_txLen   = `UAM_NODE_BRK_LAST;
          next_txState = uam_pkg::UAM_TX_START;
        end else if (sendReq) begin
          next_txShift = sendData;
          next_txLen   = nineBits ? 4'h8 : 4'h7;
          next_txState = uam_pkg::UAM_TX_START;
        end
      end
      uam_pkg::UAM_TX_START: begin
        if (txBitEnd) begin
          next_txState = uam_pkg::UAM_TX_DATA;
          next_txBit   = 4'h0;
        end
      end
      uam_pkg::UAM_TX_DATA: begin
        if (txBitEnd) begin
          next_txShift = {1'b0, txShift[8:1]};
          next_txBit   = txBit + 4'h1;
          if (txBit == txLen) begin
            next_txState = uam_pkg::UAM_TX_STOP;
          end
        end
      end
      uam_pkg::UAM_TX_STOP: begin
        if (txBitEnd) begin
          next_txState = uam_pkg::UAM_TX_IDLE;
        end
      end
      default: next_txState = uam_pkg::UAM_TX_IDLE;
    endcase
    case (next_txState)
      uam_pkg::UAM_TX_START: next_txLine = 1'b0;
      uam_pkg::UAM_TX_DATA:  next_txLine = next_txShift[0];
      default:               next_txLine = 1'b1;
    endcase
    next_busy = (next_txState != uam_pkg::UAM_TX_IDLE);

    next_rxState = rxState;
    next_rxBit   = rxBit;
    next_rxShift = rxShift;
    next_rxCnt   = rxCnt + 16'h0001;
    next_valid   = 1'b0;
    next_ferr    = rcvFrameErr;
    next_rcvData = rcvData;
    rxLast       = nineBits ? 4'h8 : 4'h7;
    case (rxState)
      uam_pkg::UAM_RX_IDLE: begin
        next_rxCnt = 16'h0000;
        if (!rxd) begin
          next_rxState = uam_pkg::UAM_RX_START;
        end
      end
      uam_pkg::UAM_RX_START: begin
        if (rxCnt == HALF_LAST) begin
          next_rxCnt   = 16'h0000;
          next_rxBit   = 4'h0;
          next_rxState = rxd ? uam_pkg::UAM_RX_IDLE : uam_pkg::UAM_RX_DATA;
        end
      end
      uam_pkg::UAM_RX_DATA: begin
        if (rxCnt == BIT_LAST) begin
          next_rxCnt   = 16'h0000;
          next_rxShift = {rxd, rxShift[8:1]};
          next_rxBit   = rxBit + 4'h1;
          if (rxBit == rxLast) begin
            next_rxState = uam_pkg::UAM_RX_STOP;
          end
        end
      end
      uam_pkg::UAM_RX_STOP: begin
        if (rxCnt == BIT_LAST) begin
          next_rxState = uam_pkg::UAM_RX_IDLE;
          next_valid   = 1'b1;
          next_ferr    = !rxd;
          next_rcvData = nineBits ? rxShift : {1'b0, rxShift[8:1]};
        end
      end
      default: next_rxState = uam_pkg::UAM_RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txState <= uam_pkg::UAM_TX_IDLE;  txCnt <= 16'h0000;  txBit <= 4'h0;
      txLen <= 4'h7;  txShift <= 9'h000;  txLine <= 1'b1;  sendBusy <= 1'b0;
      rxState <= uam_pkg::UAM_RX_IDLE;  rxCnt <= 16'h0000;  rxBit <= 4'h0;
      rxShift <= 9'h000;  rcvValid <= 1'b0;  rcvData <= 9'h000;  rcvFrameErr <= 1'b0;
    end else begin
      txState <= next_txState;  txCnt <= next_txCnt;  txBit <= next_txBit;
      txLen <= next_txLen;  txShift <= next_txShift;  txLine <= next_txLine;
      sendBusy <= next_busy;
      rxState <= next_rxState;  rxCnt <= next_rxCnt;  rxBit <= next_rxBit;
      rxShift <= next_rxShift;  rcvValid <= next_valid;  rcvData <= next_rcvData;
      rcvFrameErr <= next_ferr;
    end
  end
endmodule
`default_nettype wire

/* File: bench/uam_link_checker.sv */
// Line-level checks on the serial pair between device and node
`timescale 1ns/1ps
`default_nettype none
`include "uam_regs.svh"
module uam_link_checker #(
  parameter int BIT_CYCLES = `UAM_BIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic devTx,
  input wire logic nodeTx
);
  int devLow;
  int devHigh;
  int nodeLow;
  int nodeHigh;
  // Run lengths of each line level, in clocks
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      devLow   <= 0;
      devHigh  <= 0;
      nodeLow  <= 0;
      nodeHigh <= 0;
    end else begin
      devLow   <= devTx ? 0 : devLow + 1;
      devHigh  <= devTx ? devHigh + 1 : 0;
      nodeLow  <= nodeTx ? 0 : nodeLow + 1;
      nodeHigh <= nodeTx ? nodeHigh + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence devEnd;
    $rose(devTx);
  endsequence
  sequence nodeEnd;
    $rose(nodeTx);
  endsequence
  chk_idle_after_reset: assert property ($rose(rst_n) |-> devTx && nodeTx)
    else $error("line not idle high after reset");
  chk_dev_low_whole: assert property (devEnd |-> devLow % BIT_CYCLES == 0)
    else $error("device low run not whole bits");
  chk_dev_low_max: assert property (devLow <= 10 * BIT_CYCLES)
    else $error("device low run longer than a frame");
  chk_dev_stop_min: assert property ($fell(devTx) |-> devHigh >= BIT_CYCLES)
    else $error("device stop bit too short");
  chk_node_low_whole: assert property (nodeEnd |-> nodeLow % BIT_CYCLES == 0)
    else $error("node low run not whole bits");
  chk_node_low_max: assert property (nodeLow <= 13 * BIT_CYCLES)
    else $error("node low run too long");
  chk_node_stop_min: assert property ($fell(nodeTx) |-> nodeHigh >= BIT_CYCLES)
    else $error("node stop bit too short");
  chk_node_break_len: assert property (nodeEnd and nodeLow > 10 * BIT_CYCLES |->
    nodeLow == 13 * BIT_CYCLES) else $error("node break length wrong");
endmodule
`default_nettype wire

/* File: bench/uart_dbuf_multiproc_addr_test.sv */
// Self-checking bench: device and node UART joined on one link
`timescale 1ns/1ps
`default_nettype none
`include "uam_regs.svh"
module uart_dbuf_multiproc_addr_test;
  localparam int B = 8;
  // Bit 9 is the expected receive flag, 8:0 the frame
  localparam logic [9:0] VEC [4] = '{10'h3C2, 10'h055, 10'h1C1, 10'h3FF};
  logic       clk_sys   = 1'b0;
  logic       rst_n     = 1'b0;
  logic [2:0] regAddr   = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic       regWr     = 1'b0;
  logic       regRd     = 1'b0;
  logic       sendReq   = 1'b0;
  logic       sendBreak = 1'b0;
  logic [8:0] sendData  = 9'h000;
  logic       ispSeen   = 1'b0;
  logic [7:0] regRdData;
  logic       ispResetReq;
  logic       sendBusy;
  logic       rcvValid;
  logic [8:0] rcvData;
  logic       rcvFrameErr;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  logic [8:0] rcvQ[$];
  int         rcvT[$];
  uam_link_if link ();
  uam_device #(.BIT_CYCLES(B)) u_uam_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .ispResetReq(ispResetReq));
  uam_node #(.BIT_CYCLES(B)) u_uam_node (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
    .nineBits(1'b1), .sendReq(sendReq), .sendData(sendData), .sendBreak(sendBreak),
    .sendBusy(sendBusy), .rcvValid(rcvValid), .rcvData(rcvData), .rcvFrameErr(rcvFrameErr));
  uam_link_checker #(.BIT_CYCLES(B)) u_uam_link_checker (.clk_sys(clk_sys), .rst_n(rst_n),
    .devTx(link.devTx), .nodeTx(link.nodeTx));
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (ispResetReq === 1'b1) ispSeen <= 1'b1;
    if (rcvValid === 1'b1) begin
      rcvQ.push_back(rcvData);
      rcvT.push_back(cyc);
    end
  end
  task automatic report_and_stop();
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rdChk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e,
                       input string name);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    chk(name, {1'b0, e}, {1'b0, regRdData & m});
  endtask
  // Bounded waits; running out ends the run as a failure
  task automatic waitFor(input int n);
    for (int i = 0; i < 4000 && rcvQ.size() < n; i++) @(posedge clk_sys);
    if (rcvQ.size() < n) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic send(input logic [8:0] d, input logic brk);
    @(posedge clk_sys);
    sendData  <= d;
    sendReq   <= !brk;
    sendBreak <= brk;
    @(posedge clk_sys);
    sendReq   <= 1'b0;
    sendBreak <= 1'b0;
    #1;
    for (int i = 0; i < 4000 && sendBusy !== 1'b0; i++) @(posedge clk_sys) #1;
    if (sendBusy !== 1'b0) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdChk(`UAM_ADDR_SLAVE_ADDR_REG, 8'hFF, 8'h00, "slave_addr_reg");
    rdChk(`UAM_ADDR_SLAVE_ADDR_MASK, 8'hFF, 8'h00, "slave_addr_mask");
    rdChk(3'h7, 8'hFF, 8'h00, "unmapped");
    // Mode two first, buffering is never on in mode zero
    wr(`UAM_ADDR_CTRL, 8'h88);
    wr(`UAM_ADDR_EXT, 8'h80);
    wr(`UAM_ADDR_BUF, 8'h5A);
    rdChk(`UAM_ADDR_CTRL, 8'hFF, 8'h8A, "txFlagNow");
    // Second byte goes out with ninth bit zero
    wr(`UAM_ADDR_CTRL, 8'h80);
    wr(`UAM_ADDR_BUF, 8'hA5);
    rdChk(`UAM_ADDR_CTRL, 8'h02, 8'h00, "txFlagHeld");
    waitFor(2);
    chk("frame0", 9'h15A, rcvQ[0]);
    chk("frame1", 9'h0A5, rcvQ[1]);
    chk("spacing", 9'(11 * B), 9'(rcvT[1] - rcvT[0]));
    chk("nodeFrameErr", 9'h000, {8'h00, rcvFrameErr});
    rdChk(`UAM_ADDR_CTRL, 8'h02, 8'h02, "txFlagStop");
    wr(`UAM_ADDR_SLAVE_ADDR_REG, 8'hC0);
    wr(`UAM_ADDR_SLAVE_ADDR_MASK, 8'hFD);
    wr(`UAM_ADDR_CTRL, 8'hB0);
    foreach (VEC[i]) begin
      send(VEC[i][8:0], 1'b0);
      rdChk(`UAM_ADDR_CTRL, 8'h01, {7'h00, VEC[i][9]}, "rxFlag");
      if (VEC[i][9]) begin
        rdChk(`UAM_ADDR_BUF, 8'hFF, VEC[i][7:0], "rxByte");
        wr(`UAM_ADDR_CTRL, 8'hB0);
      end
    end
    wr(`UAM_ADDR_AUX, 8'h40);
    send(9'h000, 1'b1);
    rdChk(`UAM_ADDR_EXT, 8'h04, 8'h04, "break");
    rdChk(`UAM_ADDR_EXT, 8'h08, 8'h08, "frameErr");
    chk("ispReq", 9'h001, {8'h00, ispSeen});
    wr(`UAM_ADDR_EXT, 8'h00);
    rdChk(`UAM_ADDR_EXT, 8'h04, 8'h00, "breakClr");
    // Select set: zero ninth bit of a break gives no framing error
    wr(`UAM_ADDR_PWR, 8'h40);
    send(9'h000, 1'b1);
    rdChk(`UAM_ADDR_EXT, 8'h0C, 8'h04, "feSuppressed");
    // Buffer off: a write while shifting is dropped
    wr(`UAM_ADDR_BUF, 8'h33);
    wr(`UAM_ADDR_BUF, 8'h44);
    waitFor(3);
    repeat (30 * B) @(posedge clk_sys);
    chk("singleCnt", 9'h003, 9'(rcvQ.size()));
    chk("singleByte", 9'h033, rcvQ[2]);
    // Buffered last character with extra interrupt at end of stop
    wr(`UAM_ADDR_CTRL, 8'h80);
    wr(`UAM_ADDR_EXT, 8'hD0);
    wr(`UAM_ADDR_BUF, 8'h66);
    rdChk(`UAM_ADDR_CTRL, 8'h02, 8'h02, "txFlagLoad");
    wr(`UAM_ADDR_CTRL, 8'h80);
    rdChk(`UAM_ADDR_CTRL, 8'h02, 8'h00, "txFlagClr");
    waitFor(4);
    repeat (B) @(posedge clk_sys);
    rdChk(`UAM_ADDR_CTRL, 8'h02, 8'h02, "txFlagLast");
    chk("lastFrame", 9'h066, rcvQ[3]);
    report_and_stop();
  end
endmodule
`default_nettype wire
